/* File: design/urx_pkg.sv */
package urx_pkg;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] TICK_VERIFY_A = 4'h3;
  localparam logic [3:0] TICK_VERIFY_B = 4'h5;
  localparam logic [3:0] TICK_VERIFY_C = 4'h7;
  localparam logic [3:0] TICK_MID_A = 4'h8;
  localparam logic [3:0] TICK_MID_B = 4'h9;
  localparam logic [3:0] TICK_MID_C = 4'hA;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [8:0] DATA_RESET = 9'h000;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'h0041;
  // register map: bit positions in the status/enable/clear words
  localparam int unsigned IRQ_FULL_BIT = 0;
  localparam int unsigned IRQ_NOISE_BIT = 1;
  localparam int unsigned IRQ_FRAME_BIT = 2;
  localparam int unsigned IRQ_WIDTH = 3;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_EN = 4'hC;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h2;
  localparam logic [3:0] ADDR_BAUD = 4'h6;

  typedef struct packed {
    logic [8:0] data;
    logic noise;
    logic frame_err;
  } urx_frame_t;
endpackage

/* File: design/urx_tick_gen.sv */
`timescale 1ns/1ns
module urx_tick_gen #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clock_in,           // system clock
  input wire logic rst_in,             // sync reset
  input wire logic [WIDTH-1:0] div_in, // cycles per tick, 0 stops
  output logic tick_out                // one-cycle oversample tick
);
  logic [WIDTH-1:0] cnt_q;

  initial begin
    if (WIDTH < 2) $error("urx_tick_gen: WIDTH too small");
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || div_in == '0) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else if (cnt_q >= div_in - WIDTH'(1)) begin
      cnt_q <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + WIDTH'(1);
      tick_out <= 1'b0;
    end
  end
endmodule

/* File: design/urx_recovery.sv */
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
// How it works
// (R1) sample input once per 16x baud tick
// (R2) restart phase count after each start
// (R3) resync phase on voted one-to-zero change
// (R4) start: low after three highs, count 16
// (R5) verify start at 3,5,7; two lows
// (R6) failed verify resets count and searches
// (R7) data bit majority of 8,9,10; disagreement=noise
// (R8) start mid samples high only flag noise
// (R9) stop voted low frames error; disagreement noise
// (R10) rejected glitch sets no noise
// (R11) no stop one, including break, frames error
// (R12) frame error rises with full flag
// (R13) valid falling edges resync within frame
// (R14) stop sampling ends at tick 10 of bit bits+1 after the start edge
// (R15) eight or nine data bits by control
// (R16) completed frame loads data, sets full
// (R17) break sets error, full, clears data
// (R18) errors gathered per frame, shown with data
module urx_recovery (
  input wire logic clock_in,          // system clock
  input wire logic rst_in,            // sync reset
  input wire logic rx_in,             // serial receive line
  input wire logic [3:0] addr_in,     // register address
  input wire logic [31:0] wdata_in,   // register write data
  input wire logic wr_in,             // write strobe
  input wire logic rd_in,             // read strobe
  output logic [31:0] rdata_out,      // read data, next cycle
  output logic irq_out,               // level interrupt
  output logic rx_full_flag_out,      // receive data full
  output logic noise_detected_flag_out, // noise on last frame
  output logic frame_error_flag_out,  // framing error on last frame
  output logic [8:0] rx_data_out      // received data, bit 8 ninth
);
  typedef enum logic [1:0] {
    URX_SEARCH,
    URX_START,
    URX_BITS
  } urx_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic nine_bits_q;
  logic rx_enable_q;
  logic [15:0] baud_div_q;
  logic [2:0] irq_en_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_clr;
  logic wr_ctrl;
  logic oversample_tick;

  assign wr_ctrl = wr_in && addr_in == urx_pkg::ADDR_CTRL;
  assign irq_clr = (wr_in && addr_in == urx_pkg::ADDR_IRQ_CLR) ?
                   wdata_in[2:0] : 3'h0;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      nine_bits_q <= 1'b0;
      rx_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      nine_bits_q <= wdata_in[1]; // (R15)
      rx_enable_q <= wdata_in[0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      baud_div_q <= urx_pkg::BAUD_DIV_DEFAULT;
    end else if (wr_in && addr_in == urx_pkg::ADDR_BAUD) begin
      baud_div_q <= wdata_in[15:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_en_q <= 3'h0;
    end else if (wr_in && addr_in == urx_pkg::ADDR_IRQ_EN) begin
      irq_en_q <= wdata_in[2:0];
    end
  end

  urx_tick_gen #(
    .WIDTH(16)
  ) u_tick (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .div_in(baud_div_q),
    .tick_out(oversample_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sampling and phase

  urx_state_t state_q;
  logic [3:0] phase_q;
  logic [2:0] hist_q;
  logic [2:0] vfy_q;
  logic [2:0] mid_q;
  logic [3:0] bit_idx_q;
  logic [8:0] shift_q;
  logic noise_q;
  logic prev_bit_q;
  logic done;
  logic vote;
  logic disagree;
  logic [2:0] mids;
  logic [3:0] last_idx;
  logic start_ok;
  logic start_noise;
  logic resync;
  logic resync_early;
  urx_pkg::urx_frame_t frame;

  // sample 10 is taken this tick; earlier two held in mid_q
  assign mids = {mid_q[2], mid_q[1], rx_in};
  assign vote = (mids[2] & mids[1]) | (mids[2] & mids[0]) |
                (mids[1] & mids[0]); // (R7)
  assign disagree = !(mids == 3'b000 || mids == 3'b111); // (R7)
  // start verification: two or more lows pass, a single high is noise
  always_comb begin
    start_ok = 1'b0;
    start_noise = 1'b0;
    case (vfy_q)
      3'b000: start_ok = 1'b1;
      3'b001, 3'b010, 3'b100: begin
        start_ok = 1'b1;
        start_noise = 1'b1; // (R5)
      end
      default: begin
        start_ok = 1'b0; // (R6) (R10)
        start_noise = 1'b0;
      end
    endcase
  end
  assign last_idx = nine_bits_q ? 4'hA : 4'h9; // (R14)
  // falling edge after a voted one: the edge tick becomes tick 1;
  // early edges (past tick 10) also step on to the next bit
  assign resync_early = phase_q > urx_pkg::TICK_MID_C &&
                        bit_idx_q != last_idx; // (R3)
  assign resync = state_q == URX_BITS && prev_bit_q && !rx_in &&
                  hist_q == 3'b111 &&
                  (resync_early || phase_q < urx_pkg::TICK_MID_A); // (R13)
  assign done = oversample_tick && state_q == URX_BITS &&
                phase_q == urx_pkg::TICK_MID_C && bit_idx_q == last_idx;

  always_ff @(posedge clock_in) begin
    if (rst_in || !rx_enable_q) begin
      hist_q <= 3'h7;
    end else if (oversample_tick) begin
      hist_q <= {hist_q[1:0], rx_in}; // (R1)
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || !rx_enable_q) begin
      state_q <= URX_SEARCH;
      phase_q <= 4'h0;
      bit_idx_q <= 4'h0;
      vfy_q <= 3'h0;
      mid_q <= 3'h0;
      prev_bit_q <= 1'b0;
    end else if (oversample_tick) begin
      case (state_q)
        URX_SEARCH: begin
          if (!rx_in && hist_q == 3'b111) begin
            state_q <= URX_START; // (R4)
            phase_q <= 4'h2; // (R2)
            vfy_q <= 3'h0;
          end
        end
        URX_START: begin
          phase_q <= phase_q + 4'h1; // (R4)
          if (phase_q == urx_pkg::TICK_VERIFY_A) begin
            vfy_q[2] <= rx_in;
          end
          if (phase_q == urx_pkg::TICK_VERIFY_B) begin
            vfy_q[1] <= rx_in;
          end
          if (phase_q == urx_pkg::TICK_VERIFY_C) begin
            if ((vfy_q[2] + vfy_q[1] + rx_in) > 2'd1) begin
              state_q <= URX_SEARCH; // (R6) (R10)
              phase_q <= 4'h0;
            end
            vfy_q[0] <= rx_in;
          end
          if (phase_q == urx_pkg::TICK_MID_A) begin
            mid_q[2] <= rx_in;
          end
          if (phase_q == urx_pkg::TICK_MID_B) begin
            mid_q[1] <= rx_in;
          end
          if (phase_q == urx_pkg::TICK_MID_C) begin
            mid_q[0] <= rx_in; // (R8)
          end
          if (phase_q == urx_pkg::TICK_LAST) begin
            state_q <= URX_BITS;
            phase_q <= 4'h0;
            bit_idx_q <= 4'h1;
            prev_bit_q <= 1'b0; // (R8)
          end
        end
        URX_BITS: begin
          phase_q <= resync ? 4'h2 : phase_q + 4'h1; // (R13)
          if (resync) begin
            prev_bit_q <= 1'b0;
          end
          if (resync && resync_early) begin
            bit_idx_q <= bit_idx_q + 4'h1;
          end else if (phase_q == urx_pkg::TICK_LAST) begin
            bit_idx_q <= bit_idx_q + 4'h1;
          end
          if (phase_q == urx_pkg::TICK_MID_A) begin
            mid_q[2] <= rx_in;
          end
          if (phase_q == urx_pkg::TICK_MID_B) begin
            mid_q[1] <= rx_in;
          end
          if (phase_q == urx_pkg::TICK_MID_C) begin
            prev_bit_q <= vote; // (R3)
            if (bit_idx_q == last_idx) begin
              state_q <= URX_SEARCH; // (R14)
              phase_q <= 4'h0;
            end
          end
        end
        default: begin
          state_q <= URX_SEARCH;
        end
      endcase
    end
  end

  // data shift and per-frame noise
  always_ff @(posedge clock_in) begin
    if (rst_in || !rx_enable_q) begin
      shift_q <= urx_pkg::DATA_RESET;
      noise_q <= 1'b0;
    end else if (oversample_tick) begin
      if (state_q == URX_SEARCH) begin
        noise_q <= 1'b0; // (R10)
      end else if (state_q == URX_START &&
                   phase_q == urx_pkg::TICK_LAST) begin
        noise_q <= (start_ok && start_noise) ||
                   mid_q[2] || mid_q[1] || mid_q[0]; // (R5) (R8)
      end else if (state_q == URX_BITS &&
                   phase_q == urx_pkg::TICK_MID_C) begin
        noise_q <= noise_q | disagree; // (R7) (R9) (R18)
        if (bit_idx_q != last_idx) begin
          shift_q <= {vote, shift_q[8:1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame completion

  // any data bit voted one; still clear with a low stop means a break
  logic one_seen_q;

  always_ff @(posedge clock_in) begin
    if (rst_in || !rx_enable_q) begin
      one_seen_q <= 1'b0;
    end else if (oversample_tick) begin
      if (state_q == URX_START) begin
        one_seen_q <= 1'b0;
      end else if (state_q == URX_BITS && vote &&
                   phase_q == urx_pkg::TICK_MID_C &&
                   bit_idx_q != last_idx) begin
        one_seen_q <= 1'b1; // (R17)
      end
    end
  end

  always_comb begin
    frame.data = nine_bits_q ? shift_q : {1'b0, shift_q[8:1]};
    frame.noise = noise_q | disagree; // (R18)
    frame.frame_err = !vote; // (R9) (R11)
    if (!vote && !one_seen_q) begin
      frame.data = urx_pkg::DATA_RESET; // (R17)
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_data_out <= urx_pkg::DATA_RESET;
      noise_detected_flag_out <= 1'b0;
      frame_error_flag_out <= 1'b0;
    end else if (done) begin
      rx_data_out <= frame.data; // (R16)
      noise_detected_flag_out <= frame.noise; // (R18)
      frame_error_flag_out <= frame.frame_err; // (R12)
    end
  end

  // full: set on frame, cleared by data read; set wins
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_full_flag_out <= 1'b0;
    end else if (done) begin
      rx_full_flag_out <= 1'b1; // (R16) (R12)
    end else if (rd_in && addr_in == urx_pkg::ADDR_DATA) begin
      rx_full_flag_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts and read port

  logic [2:0] irq_set;
  assign irq_set = done ? {frame.frame_err, frame.noise, 1'b1} : 3'h0;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        urx_pkg::ADDR_CTRL: rdata_out <= {30'h0, nine_bits_q, rx_enable_q};
        urx_pkg::ADDR_DATA: rdata_out <= {20'h0, frame_error_flag_out,
            noise_detected_flag_out, rx_full_flag_out, rx_data_out};
        urx_pkg::ADDR_STATUS: rdata_out <= {29'h0, irq_stat_q};
        urx_pkg::ADDR_IRQ_EN: rdata_out <= {29'h0, irq_en_q};
        urx_pkg::ADDR_BAUD: rdata_out <= {16'h0, baud_div_q};
        default: rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end
endmodule

/* File: verification/urx_recovery_properties.sv */
`timescale 1ns/1ns
module urx_recovery_properties (
  input wire logic clock_in, // clock
  input wire logic rst_in, // sync reset
  input wire logic [3:0] addr_in, // address
  input wire logic [31:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic [31:0] rdata_out, // read data
  input wire logic irq_out, // interrupt
  input wire logic rx_full_flag_out, // full
  input wire logic noise_detected_flag_out, // noise
  input wire logic frame_error_flag_out, // framing error
  input wire logic [8:0] rx_data_out // data
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [2:0] en_q;
  logic rd_data;
  assign rd_data = rd_in && addr_in == urx_pkg::ADDR_DATA;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      en_q <= 3'h0;
    end else if (wr_in && addr_in == urx_pkg::ADDR_IRQ_EN) begin
      en_q <= wdata_in[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !rd_in |=> rdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_unmapped;
    rd_in && addr_in == 4'hF |=> rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_data_read;
    rd_data |=> rdata_out == {20'h0, $past(frame_error_flag_out),
      $past(noise_detected_flag_out), $past(rx_full_flag_out),
      $past(rx_data_out)};
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data word wrong");
  property p_full_hold;
    rx_full_flag_out && !rd_data |=> rx_full_flag_out;
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full dropped");
  property p_full_clear;
    rd_data |=> !rx_full_flag_out;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full kept");
  property p_flags_upd;
    $changed(frame_error_flag_out) || $changed(noise_detected_flag_out)
      || $changed(rx_data_out) |-> rx_full_flag_out;
  endproperty
  a_flags_upd: assert property (p_flags_upd)
    else $error("flags moved without full");
  property p_irq_off;
    en_q == 3'h0 ##1 en_q == 3'h0 |-> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  property p_irq_full;
    $rose(rx_full_flag_out) && en_q[0] |-> ##[0:2] irq_out;
  endproperty
  a_irq_full: assert property (p_irq_full)
    else $error("irq missing");
endmodule
bind urx_recovery urx_recovery_properties u_chk (.clock_in, .rst_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
  .rx_full_flag_out, .noise_detected_flag_out, .frame_error_flag_out,
  .rx_data_out);

/* File: verification/urx_tx_model.sv */
`timescale 1ns/1ns
module urx_tx_model (
  input wire logic clock_in, // clock
  output logic line_out // serial line, idle high
);
  initial line_out = 1'b1;
  // start, data lsb first, stop; flip inverts one tick
  task automatic send(input logic [8:0] d, input int nb, input logic stp,
                      input int bc, input int flip);
    logic [10:0] fr;
    fr = 11'h7FF;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++) fr[i + 1] = d[i];
    fr[nb + 1] = stp;
    for (int c = 0; c < (nb + 2) * bc; c++) begin
      line_out <= fr[c / bc] ^ (flip > 0 && c >= flip && c < flip + 4);
      @(posedge clock_in);
    end
    line_out <= 1'b1;
    repeat (2 * bc) @(posedge clock_in);
  endtask
  task automatic glitch(input int clks);
    line_out <= 1'b0;
    repeat (clks) @(posedge clock_in);
    line_out <= 1'b1;
  endtask
endmodule

/* File: verification/tb_urx_recovery.sv */
`timescale 1ns/1ns
module tb_urx_recovery;
  logic clock_in, rst_in, rx_in, wr_in, rd_in, irq, full, nf, fe;
  logic [3:0] addr_in;
  logic [31:0] wdata_in, rdata, rv;
  logic [8:0] rxd;
  int num_errors = 0, tests_run = 0, cyc = 0;
  urx_recovery u_dut (.clock_in, .rst_in, .rx_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out(rdata), .irq_out(irq),
    .rx_full_flag_out(full), .noise_detected_flag_out(nf),
    .frame_error_flag_out(fe), .rx_data_out(rxd));
  urx_tx_model u_tx (.clock_in, .line_out(rx_in));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic frame(input logic [8:0] d, input int nb, input logic stp,
                       input int bc, flip, input logic [8:0] ed,
                       input logic efe, enf);
    u_tx.send(d, nb, stp, bc, flip);
    chk("full", full, 1'b1);
    chk("data", rxd, ed);
    chk("frame err", fe, efe);
    chk("noise", nf, enf);
    rd(urx_pkg::ADDR_DATA);
    chk("data word", rv, {20'h0, efe, enf, 1'b1, ed});
    chk("full after read", full, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(urx_pkg::ADDR_STATUS);
    chk("status reset", rv, 32'h0);
    rd(4'hF);
    chk("unmapped", rv, 32'h0);
    wr(urx_pkg::ADDR_BAUD, 32'h4);
    wr(urx_pkg::ADDR_IRQ_EN, 32'h1);
    wr(urx_pkg::ADDR_CTRL, 32'h1);
    frame(9'h0A5, 8, 1'b1, 64, 0, 9'h0A5, 1'b0, 1'b0);
    chk("irq", irq, 1'b1);
    wr(urx_pkg::ADDR_IRQ_EN, 32'h0);
    @(posedge clock_in);
    #1 chk("irq masked", irq, 1'b0);
    wr(urx_pkg::ADDR_IRQ_CLR, 32'h7);
    wr(urx_pkg::ADDR_IRQ_EN, 32'h7);
    rd(urx_pkg::ADDR_STATUS);
    chk("status clear", rv, 32'h0);
    frame(9'h0A5, 8, 1'b1, 64, 98, 9'h0A5, 1'b0, 1'b1);
    frame(9'h0A5, 8, 1'b1, 64, 8, 9'h0A5, 1'b0, 1'b1);
    frame(9'h0A5, 8, 1'b1, 64, 36, 9'h0A5, 1'b0, 1'b1);
    frame(9'h000, 8, 1'b0, 64, 0, 9'h000, 1'b1, 1'b0);
    frame(9'h0FF, 8, 1'b0, 64, 0, 9'h0FF, 1'b1, 1'b0);
    frame(9'h055, 8, 1'b1, 68, 0, 9'h055, 1'b0, 1'b0);
    frame(9'h055, 8, 1'b1, 60, 0, 9'h055, 1'b0, 1'b0);
    wr(urx_pkg::ADDR_IRQ_CLR, 32'h7);
    u_tx.glitch(8);
    repeat (700) @(posedge clock_in);
    rd(urx_pkg::ADDR_STATUS);
    chk("glitch status", rv, 32'h0);
    chk("glitch irq", irq, 1'b0);
    wr(urx_pkg::ADDR_CTRL, 32'h3);
    rd(urx_pkg::ADDR_CTRL);
    chk("ctrl", rv, 32'h3);
    rd(urx_pkg::ADDR_BAUD);
    chk("baud", rv, 32'h4);
    frame(9'h1A5, 9, 1'b1, 64, 0, 9'h1A5, 1'b0, 1'b0);
    frame(9'h000, 9, 1'b0, 64, 0, 9'h000, 1'b1, 1'b0);
    wrap_up();
  end
endmodule
